// *** wwdt_core.sv ***
// Windowed watchdog: register slave, down counter, window check and fault outputs.
//
// How it works
// [RULE_01] Twelve-bit down counter loads the reload value.
// [RULE_02] Counter steps on slow clock divided by 128.
// [RULE_03] Reset gives reload 0xFFF and running watchdog.
// [RULE_04] Reset-enable comes out of reset set.
// [RULE_05] Config register accepts one write per reset.
// [RULE_06] Accepted config write reloads and restarts counter.
// [RULE_07] Valid restart reloads counter and restarts prescaler.
// [RULE_08] Restart write needs key 0xA5 in bits 31:24.
// [RULE_09] Underflow sets flag; faults when reset enabled.
// [RULE_10] Restart above delta errors, faults, no reload.
// [RULE_11] Restart at or below delta reloads cleanly.
// [RULE_12] Delta at least reload disables window check.
// [RULE_13] Flags raise interrupt only when bit 12 set.
// [RULE_14] Bit 13 enables reset; bit 14 selects processor.
// [RULE_15] Status read or reset clears flags and outputs.
// [RULE_16] Underflow flag bit 0 sticky until read.
// [RULE_17] Error flag bit 1 sticky until read.
// [RULE_18] Debug-halt bit 28 stops counter in debug.
// [RULE_19] Idle-halt bit 29 stops counter in idle.
// [RULE_20] Disable bit 15 stops the counter; window errors still fault.
// [RULE_21] Config register resets to 0x3FFF_2FFF.
// [RULE_22] Watchdog reset returns block to initial values.
// [RULE_23] Reload in bits 11:0, delta in bits 27:16.
// [RULE_24] Counter wraps past zero and keeps counting.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module wwdt_core #(
  parameter int unsigned CLK_HZ  = wwdt_pkg::CLK_HZ,
  parameter int unsigned SLOW_HZ = wwdt_pkg::SLOW_HZ
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [wwdt_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [31:0]                rdata,
  input  wire logic                       debug_state,
  input  wire logic                       idle_state,
  output logic                            irq,
  output logic                            fault,
  output logic                            fault_proc_only,
  output logic                            fault_all
);
  localparam int unsigned W = wwdt_pkg::CNT_W;

  logic [31:0]  config_reg;
  logic         config_locked;
  logic [W-1:0] counter;
  logic         underflow_flag;
  logic         window_error_flag;
  logic         dbg_meta;
  logic         dbg_sync;
  logic         idle_meta;
  logic         idle_sync;
  logic         tick;

  // Decoded fields of the configuration register.
  logic [W-1:0] reload_value;
  logic [W-1:0] window_delta;
  logic         fault_irq_enable;
  logic         fault_reset_enable;
  logic         processor_only_reset_select;
  logic         timer_disable;
  logic         debug_halt;
  logic         idle_halt;

  assign reload_value                = config_reg[wwdt_pkg::RELOAD_LSB +: W];           // [RULE_23]
  assign window_delta                = config_reg[wwdt_pkg::DELTA_LSB +: W];            // [RULE_23]
  assign fault_irq_enable            = config_reg[wwdt_pkg::IRQ_EN_BIT];
  assign fault_reset_enable          = config_reg[wwdt_pkg::RST_EN_BIT];
  assign processor_only_reset_select = config_reg[wwdt_pkg::PROC_SEL_BIT];
  assign timer_disable               = config_reg[wwdt_pkg::DISABLE_BIT];
  assign debug_halt                  = config_reg[wwdt_pkg::DBG_HALT_BIT];
  assign idle_halt                   = config_reg[wwdt_pkg::IDLE_HALT_BIT];

  // Bus decode.
  logic wr_restart;
  logic wr_config;
  logic rd_flags;
  logic key_ok;
  logic restart_req;
  logic in_window;
  logic restart_ok;
  logic restart_err;
  logic halted;
  logic step;
  logic underflow;

  assign wr_restart  = wr && (addr == wwdt_pkg::OFS_RESTART);
  assign wr_config   = wr && (addr == wwdt_pkg::OFS_CONFIG) && !config_locked;    // [RULE_05]
  assign rd_flags    = rd && (addr == wwdt_pkg::OFS_FLAGS);
  assign key_ok      = wdata[wwdt_pkg::KEY_MSB:wwdt_pkg::KEY_LSB]
                    == wwdt_pkg::RESTART_KEY;                                     // [RULE_08]
  assign restart_req = wr_restart && key_ok && wdata[wwdt_pkg::RESTART_BIT];      // [RULE_08]
  // A delta at or above the reload value opens the window over the whole range.
  assign in_window   = (counter <= window_delta)                                  // [RULE_11]
                    || (window_delta >= reload_value);                            // [RULE_12]
  // Window errors are checked even while disabled, so a stuck loop is still caught.
  assign restart_err = restart_req && !in_window;                                 // [RULE_10]
  assign restart_ok  = restart_req && in_window;                                  // [RULE_11]
  assign halted      = timer_disable                                              // [RULE_20]
                    || (debug_halt && dbg_sync)                                   // [RULE_18]
                    || (idle_halt && idle_sync);                                  // [RULE_19]
  assign step        = tick && !halted;                                           // [RULE_02]
  assign underflow   = step && (counter == '0);

  // Debug and idle indications come from other logic; synchronise before use.
  always_ff @(posedge clk) begin
    if (srst) begin
      dbg_meta  <= 1'b0;
      dbg_sync  <= 1'b0;
      idle_meta <= 1'b0;
      idle_sync <= 1'b0;
    end else begin
      dbg_meta  <= debug_state;
      dbg_sync  <= dbg_meta;
      idle_meta <= idle_state;
      idle_sync <= idle_meta;
    end
  end

  // The prescaler restarts on a good restart or an accepted config write.
  wwdt_tick #(
    .CLK_HZ  (CLK_HZ),
    .SLOW_HZ (SLOW_HZ),
    .DIV     (wwdt_pkg::SLOW_DIV)
  ) u_tick (
    .clk     (clk),
    .srst    (srst),
    .restart (restart_ok || wr_config),                                           // [RULE_07]
    .tick    (tick)
  );

  // Write-once configuration register.
  always_ff @(posedge clk) begin
    if (srst) begin
      config_reg    <= wwdt_pkg::CONFIG_RESET;                                    // [RULE_21] [RULE_03] [RULE_04]
      config_locked <= 1'b0;
    end else if (wr_config) begin
      config_reg    <= wdata & wwdt_pkg::CONFIG_MASK;
      config_locked <= 1'b1;                                                      // [RULE_05]
    end
  end

  // Down counter.
  always_ff @(posedge clk) begin
    if (srst) begin
      counter <= wwdt_pkg::CNT_MAX;                                               // [RULE_03]
    end else if (wr_config) begin
      counter <= wdata[wwdt_pkg::RELOAD_LSB +: W];                                // [RULE_06]
    end else if (restart_ok) begin
      counter <= reload_value;                                                    // [RULE_07] [RULE_01]
    end else if (step) begin
      counter <= counter - W'(1);                                                 // [RULE_24]
    end
  end

  // Sticky status flags; a new event in the read cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      underflow_flag    <= 1'b0;                                                  // [RULE_22]
      window_error_flag <= 1'b0;
    end else begin
      if (underflow) begin
        underflow_flag <= 1'b1;                                                   // [RULE_09] [RULE_16]
      end else if (rd_flags) begin
        underflow_flag <= 1'b0;                                                   // [RULE_15]
      end
      if (restart_err) begin
        window_error_flag <= 1'b1;                                                // [RULE_17]
      end else if (rd_flags) begin
        window_error_flag <= 1'b0;                                                // [RULE_15]
      end
    end
  end

  // Interrupt and reset request follow the flags one cycle later.
  logic any_fault;
  assign any_fault = underflow_flag || window_error_flag;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= any_fault && fault_irq_enable && !rd_flags;                          // [RULE_13] [RULE_15]
    end
  end

  // Underflow faults only with reset enabled; a window error always faults.
  logic fault_hold;
  logic fault_live;
  // A status read drops the reset request in the same cycle as the interrupt.
  assign fault_live = fault_hold && !rd_flags;                                    // [RULE_15]
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_hold <= 1'b0;
    end else if (underflow && fault_reset_enable) begin
      fault_hold <= 1'b1;                                                         // [RULE_09]
    end else if (restart_err) begin
      fault_hold <= 1'b1;                                                         // [RULE_10]
    end else if (rd_flags) begin
      fault_hold <= 1'b0;                                                         // [RULE_15]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault           <= 1'b0;
      fault_proc_only <= 1'b0;
      fault_all       <= 1'b0;
    end else begin
      fault           <= fault_live;                                              // [RULE_15]
      fault_proc_only <= fault_live && fault_reset_enable
                         && processor_only_reset_select;                          // [RULE_14]
      fault_all       <= fault_live && fault_reset_enable
                         && !processor_only_reset_select;                         // [RULE_14]
    end
  end

  // Read data, valid in the cycle after the strobe only.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        wwdt_pkg::OFS_CONFIG: rdata <= config_reg;
        wwdt_pkg::OFS_FLAGS: begin
          rdata                    <= '0;
          rdata[wwdt_pkg::UNF_BIT] <= underflow_flag;
          rdata[wwdt_pkg::ERR_BIT] <= window_error_flag;
        end
        default:              rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule : wwdt_core

// *** wwdt_pkg.sv ***
// Package with register map, field layout and timing constants of the windowed watchdog.
package wwdt_pkg;
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  OFS_RESTART    = 4'h0;
  localparam logic [3:0]  OFS_CONFIG     = 4'h4;
  localparam logic [3:0]  OFS_FLAGS      = 4'h8;
  localparam int unsigned CNT_W          = 12;
  localparam logic [7:0]  RESTART_KEY    = 8'hA5;
  localparam int unsigned KEY_MSB        = 31;
  localparam int unsigned KEY_LSB        = 24;
  localparam int unsigned RESTART_BIT    = 0;
  localparam int unsigned RELOAD_LSB     = 0;
  localparam int unsigned DELTA_LSB      = 16;
  localparam int unsigned IRQ_EN_BIT     = 12;
  localparam int unsigned RST_EN_BIT     = 13;
  localparam int unsigned PROC_SEL_BIT   = 14;
  localparam int unsigned DISABLE_BIT    = 15;
  localparam int unsigned DBG_HALT_BIT   = 28;
  localparam int unsigned IDLE_HALT_BIT  = 29;
  localparam int unsigned UNF_BIT        = 0;
  localparam int unsigned ERR_BIT        = 1;
  localparam logic [31:0] CONFIG_RESET   = 32'h3FFF_2FFF;
  localparam logic [31:0] CONFIG_MASK    = 32'h3FFF_FFFF;
  localparam logic [11:0] CNT_MAX        = 12'hFFF;
  localparam int unsigned SLOW_DIV       = 128;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SLOW_HZ        = 32_768;
endpackage : wwdt_pkg

// *** wwdt_tick.sv ***
// Slow clock prescaler producing one-cycle count ticks, restartable on demand.
`timescale 1ns/10ps
module wwdt_tick #(
  parameter int unsigned CLK_HZ  = wwdt_pkg::CLK_HZ,
  parameter int unsigned SLOW_HZ = wwdt_pkg::SLOW_HZ,
  parameter int unsigned DIV     = wwdt_pkg::SLOW_DIV
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic restart,
  output logic      tick
);
  // Cycles of clk per counter tick, with the slow clock period rounded down to whole cycles first.
  localparam int unsigned PERIOD = (CLK_HZ / SLOW_HZ) * DIV;
  localparam int unsigned PW     = $clog2(PERIOD + 1);
  localparam logic [PW-1:0] LAST = PW'(PERIOD - 1);

  logic [PW-1:0] count;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + PW'(1);
      tick  <= 1'b0;
    end
  end
endmodule : wwdt_tick

// *** wwdt_core_monitor.sv ***
// Concurrent checks on the ports of the windowed watchdog core.
`timescale 1ns/10ps
module wwdt_core_monitor #(
  parameter int unsigned CLK_HZ  = wwdt_pkg::CLK_HZ,
  parameter int unsigned SLOW_HZ = wwdt_pkg::SLOW_HZ
) (
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic [wwdt_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0]                 wdata,
  input wire logic                        wr,
  input wire logic                        rd,
  input wire logic [31:0]                 rdata,
  input wire logic                        debug_state,
  input wire logic                        idle_state,
  input wire logic                        irq,
  input wire logic                        fault,
  input wire logic                        fault_proc_only,
  input wire logic                        fault_all
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_proc_sel: assert property (fault_proc_only |-> fault && !fault_all)
    else $error("processor reset request without a fault");
  chk_all_sel: assert property (fault_all |-> fault && !fault_proc_only)
    else $error("full reset request without a fault");
  chk_reset_quiet: assert property (
    $fell(srst) |-> !irq && !fault && rdata == 32'h0)
    else $error("outputs not cleared by reset");
  chk_rdata_cause: assert property (rdata != 32'h0 |-> $past(rd))
    else $error("read data without a read");
  chk_restart_wo: assert property (
    $past(rd) && $past(addr) == wwdt_pkg::OFS_RESTART |-> rdata == 32'h0)
    else $error("write-only register returned data");
  chk_flags_width: assert property (
    $past(rd) && $past(addr) == wwdt_pkg::OFS_FLAGS |-> rdata[31:2] == 30'h0)
    else $error("status read shows reserved bits");
  chk_fault_hold: assert property (
    fault && !(rd && addr == wwdt_pkg::OFS_FLAGS) |=> fault)
    else $error("fault dropped without status read");
  chk_irq_hold: assert property (
    irq && !(rd && addr == wwdt_pkg::OFS_FLAGS) |=> irq)
    else $error("interrupt dropped without status read");
  chk_read_clear: assert property (
    rd && addr == wwdt_pkg::OFS_FLAGS |=> !irq && !fault)
    else $error("status read left interrupt or fault set");
  chk_cfg_top: assert property (
    $past(rd) && $past(addr) == wwdt_pkg::OFS_CONFIG |-> rdata[31:30] == 2'b00)
    else $error("config read shows bits 31:30 set");
  cov_proc: cover property (fault_proc_only);
  cov_all: cover property (fault_all);
  cov_err_read: cover property ($past(rd) && rdata[1]);
endmodule : wwdt_core_monitor
bind wwdt_core wwdt_core_monitor #(.CLK_HZ(CLK_HZ), .SLOW_HZ(SLOW_HZ)) mon (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .debug_state(debug_state), .idle_state(idle_state), .irq(irq), .fault(fault),
  .fault_proc_only(fault_proc_only), .fault_all(fault_all));

// *** wwdt_rstc_model.sv ***
// Behavioural reset controller that counts the reset requests of the watchdog.
`timescale 1ns/10ps
module wwdt_rstc_model (
  input  wire logic       clk,
  input  wire logic       fault_proc_only,
  input  wire logic       fault_all,
  output logic      [7:0] n_proc,
  output logic      [7:0] n_all
);
  logic prev_proc = 1'b0;
  logic prev_all  = 1'b0;
  // Counts are kept across srst, as the real controller lives in another reset domain.
  initial begin
    n_proc = 8'h00;
    n_all  = 8'h00;
  end
  always @(posedge clk) begin
    prev_proc <= fault_proc_only;
    prev_all  <= fault_all;
    if (fault_proc_only && !prev_proc) n_proc <= n_proc + 8'h01;
    if (fault_all && !prev_all) n_all <= n_all + 8'h01;
  end
endmodule : wwdt_rstc_model

// *** tb_windowed_watchdog_timer.sv ***
// Self-checking testbench of the windowed watchdog core.
`timescale 1ns/10ps
module tb_windowed_watchdog_timer;
  logic        clk, srst, wr, rd, debug_state, idle_state;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic        irq, fault, fault_proc_only, fault_all;
  logic [7:0]  n_proc, n_all;
  int          n_fail = 0;
  int          tests_run = 0;
  wire  [31:0] outs = {28'h0, irq, fault, fault_proc_only, fault_all};
  // Slow clock equal to the bus clock gives a tick every 128 cycles.
  wwdt_core #(.CLK_HZ(20_000_000), .SLOW_HZ(20_000_000)) uut (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .debug_state(debug_state),
    .idle_state(idle_state), .irq(irq), .fault(fault), .fault_proc_only(fault_proc_only),
    .fault_all(fault_all));
  wwdt_rstc_model rstc (.clk(clk), .fault_proc_only(fault_proc_only), .fault_all(fault_all),
    .n_proc(n_proc), .n_all(n_all));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles
  task automatic wait_fault(input int lim);
    for (int i = 0; i < lim && fault !== 1'b1; i++) cycles(1);
  endtask : wait_fault
  task automatic do_reset;
    srst <= 1'b1;
    cycles(3);
    srst <= 1'b0;
  endtask : do_reset
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    #250000;
    n_fail++;
    conclude();
  end
  initial begin
    {srst, wr, rd, debug_state, idle_state} = 5'b10000;
    addr  = 4'h0;
    wdata = 32'h0;
    do_reset();
    rd_chk(wwdt_pkg::OFS_CONFIG, wwdt_pkg::CONFIG_RESET);
    rd_chk(wwdt_pkg::OFS_RESTART, 32'h0);
    rd_chk(4'hC, 32'h0);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'hA500_0001);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h0);
    $display("end test defaults");
    wr_reg(wwdt_pkg::OFS_CONFIG, 32'h0002_7004);
    wr_reg(wwdt_pkg::OFS_CONFIG, 32'h0000_0FFF);
    rd_chk(wwdt_pkg::OFS_CONFIG, 32'h0002_7004);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'h5A00_0001);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h0);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'hA500_0001);
    cycles(1);
    chk(outs, 32'hE);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h2);
    chk(outs, 32'h0);
    // Two ticks later the counter sits at the delta, inside the window.
    cycles(300);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'hA500_0001);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h0);
    // Without a prescaler restart the underflow would already have come.
    cycles(600);
    chk(outs, 32'h0);
    wait_fault(100);
    chk(outs, 32'hE);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h1);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'hA500_0001);
    cycles(1);
    chk(outs, 32'hE);
    rd_chk(wwdt_pkg::OFS_FLAGS, 32'h2);
    $display("end test window");
    do_reset();
    chk(outs, 32'h0);
    rd_chk(wwdt_pkg::OFS_CONFIG, wwdt_pkg::CONFIG_RESET);
    debug_state <= 1'b1;
    cycles(3);
    wr_reg(wwdt_pkg::OFS_CONFIG, 32'h3001_2001);
    cycles(512);
    chk(outs, 32'h0);
    debug_state <= 1'b0;
    idle_state  <= 1'b1;
    cycles(300);
    chk(outs, 32'h0);
    idle_state <= 1'b0;
    wait_fault(400);
    chk(outs, 32'h5);
    cycles(1);
    chk({16'h0, n_proc, n_all}, 32'h0000_0301);
    $display("end test halt");
    do_reset();
    wr_reg(wwdt_pkg::OFS_CONFIG, 32'h0000_A001);
    cycles(300);
    chk(outs, 32'h0);
    wr_reg(wwdt_pkg::OFS_RESTART, 32'hA500_0001);
    cycles(1);
    chk(outs, 32'h5);
    cycles(1);
    chk({16'h0, n_proc, n_all}, 32'h0000_0302);
    $display("end test disable");
    conclude();
  end
endmodule : tb_windowed_watchdog_timer
